// ===== hdl/dpp_packet_layer.sv
// Packet layer: serial link receive parsing and reply header forming
`timescale 1ns/1ps
`default_nettype none

// Function
// - Short packet is four bytes; long packet spans six to 65,541 bytes.
// - Packets of any kind follow back to back inside one burst.
// - Bits of each byte arrive least significant first.
// - Multi-byte fields arrive low byte first.
// - Every packet starts with a four byte header.
// - Header: identifier, two payload or length bytes, then check byte.
// - Identifier holds channel in bits 7:6, type in bits 5:0.
// - Only channel zero is answered; other channels are dropped.
// - Replies carry the channel of the last answered host packet.
// - Sync event types are 01, 11, 21 and 31.
// - Control types 02, 12, 22, 32 set colour and peripheral state.
// - Generic writes 03, 13, 23; generic reads 04, 14, 24.
// - Command writes 05 and 15, command read 06.
// - Type 37 sets the largest return packet size.
// - Host long types 09, 19, 29 and 39.
// - Pixel stream long types 0E, 1E, 2E and 3E.
// - Short replies use 02, 08, 11, 12, 21 and 22.
// - Long replies use 1A and 1C.
// - Packets with undefined types drop the rest of their burst.
// - Short payload is two bytes; unused second byte is zero.
// - Long packet length field counts payload bytes after header.
// - Footer is a CRC-16 over payload, preset all ones, MSB first.
// - Header check byte corrects single data bit errors; top two bits zero.
module dpp_packet_layer (
	input  wire logic                  i_sys_clk,      // System clock
	input  wire logic                  i_rst,          // Sync reset
	input  wire logic                  i_link_clk,     // Link bit clock
	input  wire logic                  i_link_hs,      // Burst active
	input  wire logic                  i_link_sdata,   // Serial data
	output logic                       o_pkt_valid,    // Header pulse
	output logic [1:0]                 o_pkt_chan,     // Channel
	output logic [5:0]                 o_pkt_type,     // Type code
	output logic                       o_pkt_long,     // Long packet
	output logic [15:0]                o_pkt_data,     // Payload/length
	output logic                       o_pkt_fixed,    // Bit corrected
	output logic                       o_pay_valid,    // Payload pulse
	output logic [7:0]                 o_pay_byte,     // Payload byte
	output logic                       o_pay_last,     // Last payload
	output logic                       o_pkt_end,      // Footer pulse
	output logic                       o_crc_ok,       // Footer match
	output logic                       o_hdr_err,      // Bad header
	output logic                       o_color_mode,   // Colour on
	output logic                       o_periph_on,    // Peripheral on
	output logic [15:0]                o_max_ret_size, // Return limit
	input  wire logic                  i_reply_req,    // Reply request
	input  wire dpp_pkg::dpp_reply_type i_reply_kind,  // Reply kind
	input  wire logic [15:0]           i_reply_data,   // Reply payload
	input  wire logic                  i_reply_ready,  // Header taken
	output logic                       o_reply_valid,  // Header ready
	output logic [31:0]                o_reply_hdr     // Reply header
);

	// ----------------------------------------------------------------
	// Link side reset
	// ----------------------------------------------------------------
	// Link clock must run during reset for this to take effect
	logic lrst_meta_q;
	logic lrst_q;

	always_ff @(posedge i_link_clk) begin
		lrst_meta_q <= i_rst;
		lrst_q      <= lrst_meta_q;
	end

	// ----------------------------------------------------------------
	// Deserialiser
	// ----------------------------------------------------------------
	logic [2:0] bit_cnt_q;
	logic [7:0] sh_q;
	wire  [7:0] sh_d;
	wire        byte_stb;

	assign sh_d     = {i_link_sdata, sh_q[7:1]};
	assign byte_stb = i_link_hs & (bit_cnt_q == dpp_pkg::BIT_LAST);

	always_ff @(posedge i_link_clk) begin
		if (lrst_q | ~i_link_hs) begin
			bit_cnt_q <= 3'h0;
		end else begin
			bit_cnt_q <= bit_cnt_q + 3'h1;
		end
		sh_q <= sh_d;
	end

	// ----------------------------------------------------------------
	// Header decode
	// ----------------------------------------------------------------
	dpp_pkg::dpp_state_type st_q;
	logic [1:0]  hcnt_q;
	logic [23:0] hdr_q;
	wire  [7:0]  syn;
	wire  [23:0] fmask;
	wire  [23:0] hd;
	wire         ecc_unused;
	wire         hdr_good;
	wire         fixed;
	wire  [5:0]  tc;
	wire  [1:0]  chan;
	wire  [15:0] plen;
	wire         hshort;
	wire         hlong;
	wire         dshort;
	wire         dlong;
	wire         is_long;
	wire         known;
	wire         mine;
	wire         hdr_done;

	// Check byte is the current byte when the header completes
	assign syn = {sh_d[7:6], sh_d[5:0] ^ dpp_pkg::ecc6(hdr_q)};
	assign fmask      = dpp_pkg::ecc_fix(syn[5:0]);
	// Zero check byte means the sender skipped the check
	assign ecc_unused = (sh_d == 8'h00);
	assign hdr_good   = ecc_unused | (syn == 8'h00)
		| ((syn[7:6] == 2'h0) & (fmask != 24'h000000));
	assign fixed      = ~ecc_unused & (syn != 8'h00) & hdr_good;
	assign hd         = ecc_unused ? hdr_q : (hdr_q ^ fmask);
	assign tc         = hd[5:0];
	assign chan       = hd[7:6];
	assign plen       = hd[23:8];
	assign hshort = dpp_pkg::host_short(tc);
	assign hlong  = dpp_pkg::host_long(tc);
	assign dshort = dpp_pkg::dev_short(tc);
	assign dlong  = dpp_pkg::dev_long(tc);
	assign is_long = hlong | dlong;
	// Reserved codes fall outside every set
	assign known   = hshort | hlong | dshort | dlong;
	// End-of-transmission on another channel is dropped here too
	assign mine    = (chan == dpp_pkg::CHAN_SELF)
		& (hshort | hlong);
	assign hdr_done = byte_stb & (st_q == dpp_pkg::ST_HDR)
		& (hcnt_q == dpp_pkg::HDR_LAST);

	always_ff @(posedge i_link_clk) begin
		if (lrst_q | ~i_link_hs) begin
			hcnt_q <= 2'h0;
		end else if (byte_stb & (st_q == dpp_pkg::ST_HDR)) begin
			hcnt_q <= hcnt_q + 2'h1;
		end
		if (byte_stb & (st_q == dpp_pkg::ST_HDR)) begin
			hdr_q <= {sh_d, hdr_q[23:8]};
		end
	end

	// ----------------------------------------------------------------
	// Packet delineation
	// ----------------------------------------------------------------
	logic [15:0] cnt_q;
	logic [15:0] crc_q;
	logic [7:0]  ftr_lo_q;
	logic        fcnt_q;
	logic        rep_q;

	always_ff @(posedge i_link_clk) begin
		if (lrst_q | ~i_link_hs) begin
			st_q   <= dpp_pkg::ST_HDR;
			cnt_q  <= 16'h0000;
			fcnt_q <= 1'b0;
			rep_q  <= 1'b0;
		end else if (byte_stb) begin
			case (st_q)
				dpp_pkg::ST_HDR: begin
					if (hdr_done) begin
						rep_q <= mine;
						cnt_q <= plen;
						// Unknown length: rest of burst is lost
						if (~hdr_good | ~known) begin
							st_q <= dpp_pkg::ST_DROP;
						end else if (is_long & (plen == 16'h0000)) begin
							st_q <= dpp_pkg::ST_FTR;
						end else if (is_long) begin
							st_q <= dpp_pkg::ST_PAY;
						end
					end
				end
				dpp_pkg::ST_PAY: begin
					cnt_q <= cnt_q - 16'h0001;
					if (cnt_q == 16'h0001) begin
						st_q <= dpp_pkg::ST_FTR;
					end
				end
				dpp_pkg::ST_FTR: begin
					fcnt_q <= ~fcnt_q;
					if (fcnt_q) begin
						st_q <= dpp_pkg::ST_HDR;
					end
				end
				dpp_pkg::ST_DROP: begin
					st_q <= dpp_pkg::ST_DROP;
				end
				default: begin
					st_q <= dpp_pkg::ST_HDR;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Footer check
	// ----------------------------------------------------------------
	wire ftr_hi;

	assign ftr_hi = byte_stb & (st_q == dpp_pkg::ST_FTR) & fcnt_q;

	always_ff @(posedge i_link_clk) begin
		if (hdr_done) begin
			crc_q <= dpp_pkg::CRC_INIT;
		end else if (byte_stb & (st_q == dpp_pkg::ST_PAY)) begin
			crc_q <= dpp_pkg::crc_byte(crc_q, sh_d);
		end
		if (byte_stb & (st_q == dpp_pkg::ST_FTR) & ~fcnt_q) begin
			ftr_lo_q <= sh_d;
		end
	end

	// ----------------------------------------------------------------
	// Link side event holding
	// ----------------------------------------------------------------
	// Words stay put for a whole byte time, far longer than the
	// system side takes to see the toggle, so they cross safely
	logic [3:0]  tgl_q;
	logic [23:0] hdr_word_q;
	logic        hdr_fix_q;
	logic [7:0]  pay_byte_q;
	logic        pay_last_q;
	logic        end_ok_q;

	always_ff @(posedge i_link_clk) begin
		if (lrst_q) begin
			tgl_q <= 4'h0;
		end else begin
			tgl_q[0] <= tgl_q[0] ^ (hdr_done & hdr_good & mine);
			tgl_q[1] <= tgl_q[1] ^ (byte_stb & rep_q
				& (st_q == dpp_pkg::ST_PAY));
			tgl_q[2] <= tgl_q[2] ^ (ftr_hi & rep_q);
			tgl_q[3] <= tgl_q[3] ^ (hdr_done & ~hdr_good);
		end
		if (hdr_done) begin
			hdr_word_q <= hd;
			hdr_fix_q  <= fixed;
		end
		if (byte_stb & (st_q == dpp_pkg::ST_PAY)) begin
			pay_byte_q <= sh_d;
			pay_last_q <= (cnt_q == 16'h0001);
		end
		if (ftr_hi) begin
			end_ok_q <= ({sh_d, ftr_lo_q} == crc_q);
		end
	end

	// ----------------------------------------------------------------
	// System side crossing
	// ----------------------------------------------------------------
	logic [3:0] t_meta_q;
	logic [3:0] t_sync_q;
	logic [3:0] t_prev_q;
	wire  [3:0] ev;

	assign ev = t_sync_q ^ t_prev_q;

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			t_meta_q <= 4'h0;
			t_sync_q <= 4'h0;
			t_prev_q <= 4'h0;
		end else begin
			t_meta_q <= tgl_q;
			t_sync_q <= t_meta_q;
			t_prev_q <= t_sync_q;
		end
	end

	// ----------------------------------------------------------------
	// Receive outputs
	// ----------------------------------------------------------------
	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_pkt_valid <= 1'b0;
			o_pay_valid <= 1'b0;
			o_pkt_end   <= 1'b0;
			o_hdr_err   <= 1'b0;
			o_pkt_chan  <= 2'h0;
			o_pkt_type  <= 6'h00;
			o_pkt_long  <= 1'b0;
			o_pkt_data  <= 16'h0000;
			o_pkt_fixed <= 1'b0;
			o_pay_byte  <= 8'h00;
			o_pay_last  <= 1'b0;
			o_crc_ok    <= 1'b0;
		end else begin
			o_pkt_valid <= ev[0];
			o_pay_valid <= ev[1];
			o_pkt_end   <= ev[2];
			o_hdr_err   <= ev[3];
			if (ev[0]) begin
				o_pkt_chan  <= hdr_word_q[7:6];
				o_pkt_type  <= hdr_word_q[5:0];
				o_pkt_long  <= dpp_pkg::host_long(hdr_word_q[5:0]);
				o_pkt_data  <= hdr_word_q[23:8];
				o_pkt_fixed <= hdr_fix_q;
			end
			if (ev[1]) begin
				o_pay_byte <= pay_byte_q;
				o_pay_last <= pay_last_q;
			end
			if (ev[2]) begin
				o_crc_ok <= end_ok_q;
			end
		end
	end

	// ----------------------------------------------------------------
	// Control state from host packets
	// ----------------------------------------------------------------
	logic [1:0] last_chan_q;
	wire  [5:0] ev_tc;

	assign ev_tc = hdr_word_q[5:0];

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_color_mode   <= dpp_pkg::COLOR_RST;
			o_periph_on    <= dpp_pkg::PERIPH_RST;
			o_max_ret_size <= dpp_pkg::MAXRET_RST;
			last_chan_q    <= dpp_pkg::CHAN_SELF;
		end else if (ev[0]) begin
			last_chan_q <= hdr_word_q[7:6];
			case (ev_tc)
				dpp_pkg::TC_CM_OFF:  o_color_mode <= 1'b0;
				dpp_pkg::TC_CM_ON:   o_color_mode <= 1'b1;
				dpp_pkg::TC_PER_OFF: o_periph_on  <= 1'b0;
				dpp_pkg::TC_PER_ON:  o_periph_on  <= 1'b1;
				dpp_pkg::TC_MAX_RET: begin
					o_max_ret_size <= hdr_word_q[23:8];
				end
				default: begin
					o_color_mode <= o_color_mode;
				end
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Reply header forming
	// ----------------------------------------------------------------
	wire        rk_one;
	wire        rk_long;
	wire [15:0] rep_len;
	wire [15:0] rep_pl;
	wire [23:0] rep_d;

	assign rk_one  = (i_reply_kind == dpp_pkg::RK_GEN1)
		| (i_reply_kind == dpp_pkg::RK_CMD1);
	assign rk_long = (i_reply_kind == dpp_pkg::RK_GENL)
		| (i_reply_kind == dpp_pkg::RK_CMDL);
	// Long replies never exceed the size the host allowed
	assign rep_len = (i_reply_data > o_max_ret_size) ? o_max_ret_size
		: i_reply_data;
	assign rep_pl  = rk_one ? {8'h00, i_reply_data[7:0]}
		: (rk_long ? rep_len : i_reply_data);
	assign rep_d   = {rep_pl, last_chan_q,
		dpp_pkg::reply_code(i_reply_kind)};

	always_ff @(posedge i_sys_clk) begin
		if (i_rst) begin
			o_reply_valid <= 1'b0;
			o_reply_hdr   <= 32'h00000000;
		end else if (i_reply_req & ~o_reply_valid) begin
			o_reply_valid <= 1'b1;
			o_reply_hdr   <= {2'h0, dpp_pkg::ecc6(rep_d), rep_d};
		end else if (i_reply_ready) begin
			o_reply_valid <= 1'b0;
		end
	end

endmodule

`default_nettype wire

// ===== hdl/dpp_pkg.sv
// Shared constants, types and functions of the packet layer parser
package dpp_pkg;

	// ----------------------------------------------------------------
	// Header layout
	// ----------------------------------------------------------------
	localparam logic [1:0]  CHAN_SELF  = 2'h0;
	localparam logic [1:0]  HDR_LAST   = 2'h3;
	localparam logic [2:0]  BIT_LAST   = 3'h7;
	localparam logic [15:0] CRC_INIT   = 16'hffff;
	localparam logic [15:0] CRC_POLY   = 16'h1021;
	localparam logic [23:0] ECC_M0     = 24'hf12cb7;
	localparam logic [23:0] ECC_M1     = 24'hf2555b;
	localparam logic [23:0] ECC_M2     = 24'h749a6d;
	localparam logic [23:0] ECC_M3     = 24'hb8e38e;
	localparam logic [23:0] ECC_M4     = 24'hdf03f0;
	localparam logic [23:0] ECC_M5     = 24'heffc00;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic        COLOR_RST  = 1'b0;
	localparam logic        PERIPH_RST = 1'b0;
	localparam logic [15:0] MAXRET_RST = 16'h0001;

	// ----------------------------------------------------------------
	// Data type codes
	// ----------------------------------------------------------------
	localparam logic [5:0] TC_CM_OFF   = 6'h02;
	localparam logic [5:0] TC_CM_ON    = 6'h12;
	localparam logic [5:0] TC_PER_OFF  = 6'h22;
	localparam logic [5:0] TC_PER_ON   = 6'h32;
	localparam logic [5:0] TC_MAX_RET  = 6'h37;
	localparam logic [5:0] TC_R_ACKERR = 6'h02;
	localparam logic [5:0] TC_R_EOT    = 6'h08;
	localparam logic [5:0] TC_R_GEN1   = 6'h11;
	localparam logic [5:0] TC_R_GEN2   = 6'h12;
	localparam logic [5:0] TC_R_GENL   = 6'h1a;
	localparam logic [5:0] TC_R_CMDL   = 6'h1c;
	localparam logic [5:0] TC_R_CMD1   = 6'h21;
	localparam logic [5:0] TC_R_CMD2   = 6'h22;

	typedef enum logic [1:0] {
		ST_HDR  = 2'b00,
		ST_PAY  = 2'b01,
		ST_FTR  = 2'b11,
		ST_DROP = 2'b10
	} dpp_state_type;

	typedef enum logic [2:0] {
		RK_ACK_ERR = 3'h0,
		RK_EOT     = 3'h1,
		RK_GEN1    = 3'h2,
		RK_GEN2    = 3'h3,
		RK_CMD1    = 3'h4,
		RK_CMD2    = 3'h5,
		RK_GENL    = 3'h6,
		RK_CMDL    = 3'h7
	} dpp_reply_type;

	// ----------------------------------------------------------------
	// Functions
	// ----------------------------------------------------------------
	function automatic logic host_short(input logic [5:0] tc);
		case (tc)
			6'h01, 6'h11, 6'h21, 6'h31, 6'h08,
			6'h02, 6'h12, 6'h22, 6'h32,
			6'h03, 6'h13, 6'h23, 6'h04, 6'h14, 6'h24,
			6'h05, 6'h15, 6'h06, 6'h37: host_short = 1'b1;
			default: host_short = 1'b0;
		endcase
	endfunction

	function automatic logic host_long(input logic [5:0] tc);
		case (tc)
			6'h09, 6'h19, 6'h29, 6'h39,
			6'h0e, 6'h1e, 6'h2e, 6'h3e: host_long = 1'b1;
			default: host_long = 1'b0;
		endcase
	endfunction

	function automatic logic dev_long(input logic [5:0] tc);
		dev_long = (tc == TC_R_GENL) || (tc == TC_R_CMDL);
	endfunction

	function automatic logic dev_short(input logic [5:0] tc);
		case (tc)
			TC_R_ACKERR, TC_R_EOT, TC_R_GEN1, TC_R_GEN2,
			TC_R_CMD1, TC_R_CMD2: dev_short = 1'b1;
			default: dev_short = 1'b0;
		endcase
	endfunction

	function automatic logic [5:0] ecc6(input logic [23:0] d);
		ecc6 = {^(d & ECC_M5), ^(d & ECC_M4), ^(d & ECC_M3),
			^(d & ECC_M2), ^(d & ECC_M1), ^(d & ECC_M0)};
	endfunction

	// One-hot mask of the data bit that a syndrome points at
	function automatic logic [23:0] ecc_fix(input logic [5:0] syn);
		ecc_fix = 24'h000000;
		for (int i = 0; i < 24; i++) begin
			if (ecc6(24'h000001 << i) == syn) begin
				ecc_fix[i] = 1'b1;
			end
		end
	endfunction

	function automatic logic [15:0] crc_byte(input logic [15:0] c,
		input logic [7:0] b);
		logic fb;
		crc_byte = c;
		for (int i = 7; i >= 0; i--) begin
			fb = crc_byte[15] ^ b[i];
			crc_byte = {crc_byte[14:0], 1'b0} ^ (fb ? CRC_POLY : 16'h0000);
		end
	endfunction

	function automatic logic [5:0] reply_code(input dpp_reply_type k);
		case (k)
			RK_ACK_ERR: reply_code = TC_R_ACKERR;
			RK_EOT:     reply_code = TC_R_EOT;
			RK_GEN1:    reply_code = TC_R_GEN1;
			RK_GEN2:    reply_code = TC_R_GEN2;
			RK_CMD1:    reply_code = TC_R_CMD1;
			RK_CMD2:    reply_code = TC_R_CMD2;
			RK_GENL:    reply_code = TC_R_GENL;
			default:    reply_code = TC_R_CMDL;
		endcase
	endfunction

endpackage

// ===== bench/dpp_host_tx.sv
// Host transmitter model driving the serial link
`timescale 1ns/1ps
`default_nettype none
module dpp_host_tx (
	output logic o_link_clk,   // Link clock, still between bursts
	output logic o_link_hs,    // Burst active
	output logic o_link_sdata  // Serial data
);
	logic [7:0] q[$];

	initial begin
		o_link_clk = 1'b0;
		o_link_hs = 1'b0;
		o_link_sdata = 1'b0;
	end

	task automatic put(input logic [7:0] b);
		q.push_back(b);
	endtask

	task automatic tick();
		#62.5 o_link_clk = 1'b1;
		#62.5 o_link_clk = 1'b0;
	endtask

	task automatic idle(input int n);
		repeat (n) tick();
	endtask

	// Queued packets go out back to back in one burst
	task automatic send();
		logic [7:0] b;
		#13;
		o_link_hs = 1'b1;
		while (q.size() > 0) begin
			b = q.pop_front();
			for (int i = 0; i < 8; i++) begin
				o_link_sdata = b[i];
				tick();
			end
		end
		o_link_hs = 1'b0;
		// Released line must not keep showing the last bit
		o_link_sdata = ~o_link_sdata;
		idle(2);
	endtask
endmodule
`default_nettype wire

// ===== bench/dpp_checker.sv
// Concurrent checks on the packet layer ports
`timescale 1ns/1ps
`default_nettype none
module dpp_checker (
	input wire logic        i_sys_clk,     // Clock
	input wire logic        i_rst,         // Reset
	input wire logic        o_pkt_valid,   // Header pulse
	input wire logic [1:0]  o_pkt_chan,    // Channel
	input wire logic [5:0]  o_pkt_type,    // Type
	input wire logic        o_pkt_long,    // Long flag
	input wire logic        o_color_mode,  // Colour
	input wire logic        i_reply_req,   // Reply request
	input wire logic        i_reply_ready, // Reply taken
	input wire logic        o_reply_valid, // Reply valid
	input wire logic [31:0] o_reply_hdr    // Reply header
);
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);

	hdr_chan_a: assert property (o_pkt_valid |-> o_pkt_chan == 2'h0)
		else $error("header reported on foreign channel");
	hdr_len_a: assert property (o_pkt_valid |-> o_pkt_long ==
		(o_pkt_type[3:0] == 4'h9 || o_pkt_type[3:0] == 4'he))
		else $error("long flag disagrees with type");
	col_set_a: assert property ($rose(o_color_mode) |->
		o_pkt_type == 6'h12)
		else $error("colour set without its command");
	col_clr_a: assert property ($fell(o_color_mode) |->
		o_pkt_type == 6'h02)
		else $error("colour cleared without its command");
	rep_take_a: assert property (i_reply_req && !o_reply_valid
		|=> o_reply_valid)
		else $error("reply request not taken");
	rep_hold_a: assert property (o_reply_valid && !i_reply_ready
		|=> o_reply_valid && $stable(o_reply_hdr))
		else $error("reply header changed before taken");
	rep_drop_a: assert property (o_reply_valid && i_reply_ready
		|=> !o_reply_valid)
		else $error("reply valid not dropped");
	rep_chan_a: assert property (o_reply_valid |->
		o_reply_hdr[7:6] == o_pkt_chan)
		else $error("reply channel differs");
	rep_chk_a: assert property (o_reply_valid |->
		o_reply_hdr[31:30] == 2'b00)
		else $error("reply check top bits set");
	rep_code_a: assert property (o_reply_valid |->
		o_reply_hdr[5:0] inside {6'h02, 6'h08, 6'h11, 6'h12,
		6'h21, 6'h22, 6'h1a, 6'h1c})
		else $error("reply type not a device code");
	rep_one_a: assert property (o_reply_valid &&
		o_reply_hdr[5:0] inside {6'h11, 6'h21} |->
		o_reply_hdr[23:16] == 8'h00)
		else $error("one byte reply has nonzero second byte");

	cover property (o_pkt_valid && o_pkt_long);
	cover property ($fell(o_color_mode));
	cover property (o_reply_valid && i_reply_req);
endmodule

bind dpp_packet_layer dpp_checker u_chk (.i_sys_clk, .i_rst,
	.o_pkt_valid, .o_pkt_chan, .o_pkt_type, .o_pkt_long, .o_color_mode,
	.i_reply_req, .i_reply_ready, .o_reply_valid, .o_reply_hdr);
`default_nettype wire

// ===== bench/tb.sv
// Self-checking bench of the packet layer parser
`timescale 1ns/1ps
`default_nettype none
module tb;
	localparam logic [15:0] MAXR = 16'h0002;
	logic i_sys_clk = 1'b0;
	logic i_rst = 1'b1;
	logic i_reply_req = 1'b0;
	logic i_reply_ready = 1'b0;
	logic [15:0] i_reply_data = 16'h0000;
	dpp_pkg::dpp_reply_type i_reply_kind = dpp_pkg::RK_ACK_ERR;
	logic i_link_clk, i_link_hs, i_link_sdata;
	logic o_pkt_valid, o_pkt_long, o_pkt_fixed, o_pay_valid, o_pay_last;
	logic o_pkt_end, o_crc_ok, o_hdr_err, o_color_mode, o_periph_on;
	logic o_reply_valid;
	logic [1:0] o_pkt_chan;
	logic [5:0] o_pkt_type;
	logic [15:0] o_pkt_data, o_max_ret_size;
	logic [7:0] o_pay_byte;
	logic [31:0] o_reply_hdr;
	int num_errors = 0;
	int checks = 0;
	int cyc = 0;
	int herr = 0;
	logic [23:0] qh[$];
	logic [8:0] qp[$];
	logic qe[$];
	logic [5:0] sh[14] = '{6'h01, 6'h11, 6'h21, 6'h31, 6'h08, 6'h03,
		6'h13, 6'h23, 6'h04, 6'h14, 6'h24, 6'h05, 6'h15, 6'h06};
	logic [5:0] lg[8] = '{6'h09, 6'h19, 6'h29, 6'h39,
		6'h0e, 6'h1e, 6'h2e, 6'h3e};
	logic [5:0] rc[8] = '{6'h02, 6'h08, 6'h11, 6'h12,
		6'h21, 6'h22, 6'h1a, 6'h1c};

	dpp_host_tx u_host (.o_link_clk(i_link_clk), .o_link_hs(i_link_hs),
		.o_link_sdata(i_link_sdata));

	dpp_packet_layer u_dut (.i_sys_clk, .i_rst, .i_link_clk, .i_link_hs,
		.i_link_sdata, .o_pkt_valid, .o_pkt_chan, .o_pkt_type, .o_pkt_long,
		.o_pkt_data, .o_pkt_fixed, .o_pay_valid, .o_pay_byte, .o_pay_last,
		.o_pkt_end, .o_crc_ok, .o_hdr_err, .o_color_mode, .o_periph_on,
		.o_max_ret_size, .i_reply_req, .i_reply_kind, .i_reply_data,
		.i_reply_ready, .o_reply_valid, .o_reply_hdr);

	function automatic logic [5:0] ecc(input logic [23:0] d);
		logic [23:0] m[6] = '{24'hf12cb7, 24'hf2555b, 24'h749a6d,
			24'hb8e38e, 24'hdf03f0, 24'heffc00};
		for (int i = 0; i < 6; i++)
			ecc[i] = ^(d & m[i]);
	endfunction

	function automatic logic [15:0] crc(input logic [15:0] c,
		input logic [7:0] b);
		crc = c;
		for (int i = 7; i >= 0; i--)
			crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ b[i]) ? 16'h1021 : 16'h0);
	endfunction

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic test_done();
		if (num_errors == 0 && checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Header with optional bit errors; rep marks it as reported
	task automatic pkt(input logic [7:0] idb, input logic [15:0] d,
		input logic [23:0] fl, input bit rep);
		logic [31:0] w;
		w = {2'b00, ecc({d, idb}), {d, idb} ^ fl};
		for (int i = 0; i < 4; i++)
			u_host.put(w[8 * i +: 8]);
		if (rep)
			qh.push_back({idb[3:0] == 4'h9 || idb[3:0] == 4'he, idb[5:0],
				d, fl != 24'h0});
	endtask

	task automatic lpk(input logic [5:0] tc, input logic [15:0] n,
		input bit bad);
		logic [15:0] c;
		logic [7:0] b;
		c = 16'hffff;
		pkt({2'b00, tc}, n, 24'h0, 1'b1);
		for (int i = 0; i < n; i++) begin
			b = 8'($urandom);
			c = crc(c, b);
			u_host.put(b);
			qp.push_back({i == n - 1, b});
		end
		u_host.put(c[7:0] ^ {7'h0, bad});
		u_host.put(c[15:8]);
		qe.push_back(!bad);
	endtask

	task automatic burst();
		u_host.send();
		repeat (12) @(negedge i_sys_clk);
	endtask

	// Second request while valid is high must be refused
	task automatic reply(input int k, input logic [15:0] d);
		logic [23:0] h;
		h = {(k == 2 || k == 4) ? 8'h00 : d[15:8], d[7:0], 2'b00, rc[k]};
		if (k > 5)
			h[23:8] = (d > MAXR) ? MAXR : d;
		@(posedge i_sys_clk);
		i_reply_req <= 1'b1;
		i_reply_kind <= dpp_pkg::dpp_reply_type'(k);
		i_reply_data <= d;
		@(posedge i_sys_clk);
		i_reply_data <= ~d;
		repeat (2) @(negedge i_sys_clk);
		check(o_reply_hdr, {2'b00, ecc(h), h});
		@(posedge i_sys_clk);
		i_reply_req <= 1'b0;
		i_reply_ready <= 1'b1;
		@(posedge i_sys_clk);
		i_reply_ready <= 1'b0;
		@(negedge i_sys_clk);
		check(o_reply_valid, 1'b0);
	endtask

	always #20 i_sys_clk = ~i_sys_clk;

	always @(posedge i_sys_clk) begin
		cyc++;
		if (cyc == 40000) begin
			num_errors++;
			test_done();
		end
	end

	always @(negedge i_sys_clk) begin
		if (o_pkt_valid === 1'b1)
			check({o_pkt_long, o_pkt_type, o_pkt_data, o_pkt_fixed},
				qh.size() ? qh.pop_front() : 24'hx);
		if (o_pay_valid === 1'b1)
			check({o_pay_last, o_pay_byte},
				qp.size() ? qp.pop_front() : 9'hx);
		if (o_pkt_end === 1'b1)
			check(o_crc_ok, qe.size() ? qe.pop_front() : 1'bx);
		if (o_hdr_err === 1'b1)
			herr++;
	end

	initial begin
		void'($urandom(49965));
		u_host.idle(3);
		repeat (6) @(posedge i_sys_clk);
		i_rst <= 1'b0;
		u_host.idle(3);
		@(negedge i_sys_clk);
		check({o_color_mode, o_periph_on, o_max_ret_size}, 18'h00001);
		pkt(8'h05, 16'h0010, 24'h0, 1'b1);
		lpk(6'h29, 16'h0003, 1'b0);
		pkt(8'h12, 16'h0000, 24'h0, 1'b1);
		pkt(8'h37, MAXR, 24'h0, 1'b1);
		pkt(8'h32, 16'h0000, 24'h0, 1'b1);
		burst();
		check({o_color_mode, o_periph_on, o_max_ret_size}, {2'b11, MAXR});
		pkt(8'h42, 16'h0000, 24'h0, 1'b0);
		burst();
		check(o_color_mode, 1'b1);
		pkt(8'h02, 16'h0000, 24'h000100, 1'b1);
		lpk(6'h0e, 16'h0002, 1'b1);
		burst();
		check(o_color_mode, 1'b0);
		pkt(8'h22, 16'h0000, 24'h000003, 1'b0);
		pkt(8'h22, 16'h0000, 24'h0, 1'b0);
		burst();
		pkt(8'h10, 16'h0000, 24'h0, 1'b0);
		pkt(8'h22, 16'h0000, 24'h0, 1'b0);
		burst();
		check({o_periph_on, 8'(herr)}, 9'h101);
		foreach (sh[i])
			pkt({2'b00, sh[i]}, 16'($urandom), 24'h0, 1'b1);
		foreach (lg[i])
			lpk(lg[i], 16'($urandom_range(0, 3)), 1'b0);
		pkt(8'h22, 16'h0000, 24'h0, 1'b1);
		burst();
		check(o_periph_on, 1'b0);
		check(qh.size() + qp.size() + qe.size(), 0);
		for (int k = 0; k < 8; k++)
			reply(k, 16'($urandom));
		reply(7, 16'h0001);
		test_done();
	end
endmodule
`default_nettype wire
